// *** hw/ct_clock_timer.sv ***
// clock timer: 8-bit tick counter, tap interrupts, wishbone registers
//
// Operation
// - 8-bit up-counter clocked by 256 Hz tick divided from low-frequency clock
// - software reads every counter bit, taps 128 Hz down to 1 Hz
// - falling edges of 32, 8, 2, 1 Hz taps set separate flags
// - one enable per flag; cleared enable blocks that flag's request
// - two-bit priority field, level 0 to 3, requests shown at that level
// - vector 00001CH for 32 Hz, 00001EH for 8 Hz
// - vector 000020H for 2 Hz, 000022H for 1 Hz
module ct_clock_timer
  import ct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_freq_clock_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic [1:0] irq_level_o,
  output logic [23:0] irq_vector_o
);

  // counter bit that feeds each flag
  function automatic int ct_tap_pos(input int idx);
    case (idx)
      CT_F32: ct_tap_pos = CT_TAP32;
      CT_F8: ct_tap_pos = CT_TAP8;
      CT_F2: ct_tap_pos = CT_TAP2;
      default: ct_tap_pos = CT_TAP1;
    endcase
  endfunction

  // ************************************************************
  // oscillator input synchroniser
  // ************************************************************
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic osc_level;
  logic osc_rise;
  logic tick256;

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      osc_level <= 1'b0;
    end
    else
    begin
      osc_s1 <= low_freq_clock_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      if (osc_s2 == osc_s3)
      begin
        osc_level <= osc_s3;
      end
    end
  end

  assign osc_rise = (osc_s2 == osc_s3) && osc_s3 && !osc_level;

  ct_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(osc_rise),
    .tick_o(tick256)
  );

  // ************************************************************
  // tick counter
  // ************************************************************
  logic [CT_CNT_W-1:0] count;
  logic [CT_CNT_W-1:0] count_prev;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= CT_CNT_RST;
    end
    else if (tick256)
    begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_prev <= CT_CNT_RST;
    end
    else
    begin
      count_prev <= count;
    end
  end

  // ************************************************************
  // wishbone slave
  // ************************************************************
  ct_bus_e bus_state;
  logic wr_en;
  logic wr_flag;
  logic wr_enable;
  logic wr_prio;
  logic [31:0] next_rdata;
  logic [CT_NFLAG-1:0] flag;
  logic [CT_NFLAG-1:0] enable;
  logic [1:0] prio;

  // one wait state; writes land on the acknowledged edge
  assign wb_ack_o = (bus_state == CT_BUS_ACK);
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_flag = wr_en && (wb_adr_i == CT_OFS_FLAG);
  assign wr_enable = wr_en && (wb_adr_i == CT_OFS_ENABLE);
  assign wr_prio = wr_en && (wb_adr_i == CT_OFS_PRIO);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state <= CT_BUS_IDLE;
    end
    else
    begin
      case (bus_state)
        CT_BUS_IDLE:
        begin
          if (wb_cyc_i && wb_stb_i)
          begin
            bus_state <= CT_BUS_ACK;
          end
        end
        CT_BUS_ACK: bus_state <= CT_BUS_IDLE;
        default: bus_state <= CT_BUS_IDLE;
      endcase
    end
  end

  // unmapped offsets read as zero and ignore writes
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      CT_OFS_COUNT: next_rdata = {24'h00_0000, count};
      CT_OFS_FLAG: next_rdata = {28'h000_0000, flag};
      CT_OFS_ENABLE: next_rdata = {28'h000_0000, enable};
      CT_OFS_PRIO: next_rdata = {30'h0000_0000, prio};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (bus_state == CT_BUS_IDLE && wb_cyc_i && wb_stb_i && !wb_we_i)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable <= CT_ENABLE_RST;
    end
    else if (wr_enable)
    begin
      enable <= wb_dat_i[CT_NFLAG-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prio <= CT_PRIO_RST;
    end
    else if (wr_prio)
    begin
      prio <= wb_dat_i[1:0];
    end
  end

  // ************************************************************
  // tap flags
  // ************************************************************
  logic [CT_NFLAG-1:0] tap_fall;

  // a falling tap beats a same-cycle clear so no tick is lost
  for (genvar g = 0; g < CT_NFLAG; g++)
  begin : g_flag
    assign tap_fall[g] = count_prev[ct_tap_pos(g)] && !count[ct_tap_pos(g)];

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        flag[g] <= CT_FLAG_RST[g];
      end
      else if (tap_fall[g])
      begin
        flag[g] <= 1'b1;
      end
      else if (wr_flag && wb_dat_i[g])
      begin
        flag[g] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // interrupt request
  // ************************************************************
  logic [CT_NFLAG-1:0] pending;
  logic [23:0] next_vector;

  assign pending = flag & enable;

  // lowest vector wins when several taps are pending
  always_comb
  begin
    next_vector = CT_VEC_NONE;
    if (pending[CT_F32])
    begin
      next_vector = CT_VEC_32;
    end
    else if (pending[CT_F8])
    begin
      next_vector = CT_VEC_8;
    end
    else if (pending[CT_F2])
    begin
      next_vector = CT_VEC_2;
    end
    else if (pending[CT_F1])
    begin
      next_vector = CT_VEC_1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      irq_level_o <= 2'h0;
      irq_vector_o <= CT_VEC_NONE;
    end
    else
    begin
      irq_o <= |pending;
      irq_level_o <= (|pending) ? prio : 2'h0;
      irq_vector_o <= next_vector;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_count_step: assert property (tick256 |=> count == $past(count) + 8'h01)
    else $error("counter did not advance on tick");
  a_count_hold: assert property (!tick256 |=> count == $past(count))
    else $error("counter moved without tick");
  a_count_read: assert property (
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == CT_OFS_COUNT
      |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(count)})
    else $error("counter read returned wrong value");
  a_flag_set: assert property (
      |tap_fall |=> (flag & $past(tap_fall)) == $past(tap_fall))
    else $error("tap fall did not set its flag");
  a_flag_sticky: assert property (!wr_flag |=> ($past(flag) & ~flag) == 4'h0)
    else $error("flag dropped without software clear");
  a_flag_clear: assert property (
      wr_flag && wb_dat_i[0] && !tap_fall[0] |=> !flag[0])
    else $error("write one did not clear flag");
  a_irq_mask: assert property (##1 irq_o == |$past(flag & enable))
    else $error("irq does not follow enabled flags");
  a_irq_level: assert property (##1 irq_level_o == (irq_o ? $past(prio) : 2'h0))
    else $error("irq level differs from priority");
  a_vector_32: assert property ($past(pending[CT_F32]) |-> irq_vector_o == CT_VEC_32)
    else $error("wrong vector for 32 Hz");
  a_vector_1: assert property (
      $past(pending) == 4'b1000 |-> irq_vector_o == CT_VEC_1)
    else $error("wrong vector for 1 Hz");
  a_vector_8: assert property (
      $past(pending[CT_F8:CT_F32]) == 2'b10 |-> irq_vector_o == CT_VEC_8)
    else $error("wrong vector for 8 Hz");
  a_vector_2: assert property (
      $past(pending[CT_F2:CT_F32]) == 3'b100 |-> irq_vector_o == CT_VEC_2)
    else $error("wrong vector for 2 Hz");
  a_vector_none: assert property (!irq_o |-> irq_vector_o == CT_VEC_NONE)
    else $error("vector shown without request");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after one wait");

  // ************************************************************
  // register, flag source and oscillator edge assertions
  // ************************************************************
  // a flag may only rise from a tap fall seen one edge earlier
  a_flag_cause: assert property (
      ((flag & ~$past(flag)) & ~$past(tap_fall)) == 4'h0)
    else $error("flag set without tap fall");
  a_osc_single: assert property (osc_rise |=> !osc_rise)
    else $error("one oscillator edge counted twice");
  a_enable_write: assert property (wr_enable |=> enable == $past(wb_dat_i[CT_NFLAG-1:0]))
    else $error("enable write lost");
  a_prio_write: assert property (wr_prio |=> prio == $past(wb_dat_i[1:0]))
    else $error("priority write lost");
  // byte lane 0 carries every field, so a write without it changes nothing
  a_sel_guard: assert property (
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !wb_sel_i[0]
      |=> $stable(enable) && $stable(prio))
    else $error("write without lane 0 changed a register");

  c_tap1_fall: cover property (tap_fall[CT_F1]);
  c_tap8_fall: cover property (tap_fall[CT_F8]);
  c_set_and_clear: cover property (tap_fall[0] && wr_flag && wb_dat_i[0]);
  c_irq_rise: cover property (!irq_o ##1 irq_o);
  c_prio_write: cover property (wr_prio && wb_dat_i[1:0] == 2'h3);

endmodule // ct_clock_timer

// *** hw/ct_pkg.sv ***
// constants shared by the clock timer files
package ct_pkg;

  // ************************************************************
  // clock and divider
  // ************************************************************
  localparam int CT_CLK_HZ = 100_000_000;
  localparam int CT_OSC_HZ = 32768;
  localparam int CT_TICK_HZ = 256;
  localparam int CT_PRESCALE = CT_OSC_HZ / CT_TICK_HZ;
  localparam int CT_PRE_W = 7;
  localparam logic [CT_PRE_W-1:0] CT_PRE_LAST = CT_PRE_W'(CT_PRESCALE - 1);
  localparam int CT_CNT_W = 8;
  localparam logic [CT_CNT_W-1:0] CT_CNT_RST = 8'h00;

  // ************************************************************
  // interrupt taps, flag positions and vectors
  // ************************************************************
  localparam int CT_NFLAG = 4;
  localparam int CT_TAP32 = 2;
  localparam int CT_TAP8 = 4;
  localparam int CT_TAP2 = 6;
  localparam int CT_TAP1 = 7;
  localparam int CT_F32 = 0;
  localparam int CT_F8 = 1;
  localparam int CT_F2 = 2;
  localparam int CT_F1 = 3;
  localparam logic [23:0] CT_VEC_32 = 24'h00001c;
  localparam logic [23:0] CT_VEC_8 = 24'h00001e;
  localparam logic [23:0] CT_VEC_2 = 24'h000020;
  localparam logic [23:0] CT_VEC_1 = 24'h000022;
  localparam logic [23:0] CT_VEC_NONE = 24'h000000;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CT_OFS_COUNT = 8'h00;
  localparam logic [7:0] CT_OFS_FLAG = 8'h04;
  localparam logic [7:0] CT_OFS_ENABLE = 8'h08;
  localparam logic [7:0] CT_OFS_PRIO = 8'h0c;
  localparam logic [3:0] CT_FLAG_RST = 4'h0;
  localparam logic [3:0] CT_ENABLE_RST = 4'h0;
  localparam logic [1:0] CT_PRIO_RST = 2'h0;

  typedef enum logic [1:0] {
    CT_BUS_IDLE = 2'b01,
    CT_BUS_ACK = 2'b10
  } ct_bus_e;

endpackage

// *** hw/ct_prescaler.sv ***
// divides oscillator edges down to the 256 Hz counter tick
module ct_prescaler
  import ct_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  output logic tick_o
);

  logic [CT_PRE_W-1:0] div;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div <= '0;
      tick_o <= 1'b0;
    end
    else if (step_i)
    begin
      if (div == CT_PRE_LAST)
      begin
        div <= '0;
        tick_o <= 1'b1;
      end
      else
      begin
        div <= div + 7'h01;
        tick_o <= 1'b0;
      end
    end
    else
    begin
      tick_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tick_on_wrap: assert property (step_i && div == CT_PRE_LAST |=> tick_o)
    else $error("tick missing at divider wrap");
  a_tick_only_wrap: assert property (tick_o |-> $past(step_i) && div == '0)
    else $error("tick without divider wrap");

endmodule // ct_prescaler

// *** tb/ct_clock_timer_tb.sv ***
// self-checking bench for the clock timer: counter, tap flags, masking, level, vectors
module ct_clock_timer_tb
  import ct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] osc_div = 2'h0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_sel = 4'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [1:0] irq_level_o;
  logic [23:0] irq_vector_o;
  int bad_count = 0;
  int n_checks = 0;
  int cyc_n = 0;
  logic [7:0] cnt_exp [4] = '{8'h08, 8'h20, 8'h80, 8'h00};
  logic [23:0] vec_exp [4] = '{CT_VEC_32, CT_VEC_8, CT_VEC_2, CT_VEC_1};

  ct_clock_timer i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .low_freq_clock_i(osc_div[1]),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .irq_o(irq_o),
    .irq_level_o(irq_level_o),
    .irq_vector_o(irq_vector_o)
  );

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // oscillator runs far above nominal so a full counter wrap fits in the run
  always @(posedge clk_i)
  begin
    osc_div <= osc_div + 2'h1;
    cyc_n <= cyc_n + 1;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] s, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= s;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20)
      chk("wb_ack", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, 4'hf, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, 4'hf, a, 32'h0, q);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] q;
    rd(CT_OFS_COUNT, q);
    chk("count", q, 32'h0);
    rd(CT_OFS_FLAG, q);
    chk("flags", q, 32'h0);
    rd(CT_OFS_ENABLE, q);
    chk("enables", q, 32'h0);
    wb(1'b1, 4'he, CT_OFS_ENABLE, 32'hf, q);
    rd(CT_OFS_ENABLE, q);
    chk("enables_sel_off", q, 32'h0);
    rd(CT_OFS_PRIO, q);
    chk("prio", q, 32'h0);
    rd(8'h10, q);
    chk("unmapped", q, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h0);
  endtask

  // 128 osc rises at one rise per 4 clocks gives one tick per 512 clocks
  task automatic t_rate();
    logic [31:0] q0;
    logic [31:0] q;
    int t1;
    rd(CT_OFS_COUNT, q0);
    q = q0;
    while (q === q0 && cyc_n < 5000)
      rd(CT_OFS_COUNT, q);
    t1 = cyc_n;
    q0 = q;
    while (q === q0 && cyc_n < 5000)
      rd(CT_OFS_COUNT, q);
    chk("tick_gap", {31'h0, (cyc_n - t1 >= 506) && (cyc_n - t1 <= 518)}, 32'h1);
    chk("count_step", q - q0, 32'h1);
  endtask

  task automatic t_tap(input int k);
    logic [31:0] q;
    int n;
    n = 0;
    wr(CT_OFS_PRIO, 32'(3 - k));
    wr(CT_OFS_ENABLE, 32'h1 << k);
    wr(CT_OFS_FLAG, 32'hf);
    q = 32'h0;
    while (q[k] !== 1'b1 && n < 50000)
    begin
      rd(CT_OFS_FLAG, q);
      n++;
    end
    rd(CT_OFS_COUNT, q);
    chk("count_at_flag", q, {24'h0, cnt_exp[k]});
    @(posedge clk_i);
    chk("irq", {31'h0, irq_o}, 32'h1);
    chk("irq_level", {30'h0, irq_level_o}, 32'(3 - k));
    chk("irq_vector", {8'h0, irq_vector_o}, {8'h0, vec_exp[k]});
    wr(CT_OFS_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    rd(CT_OFS_FLAG, q);
    chk("flag_kept", {31'h0, q[k]}, 32'h1);
    wr(CT_OFS_FLAG, 32'h0);
    rd(CT_OFS_FLAG, q);
    chk("flag_zero_write", {31'h0, q[k]}, 32'h1);
    wr(CT_OFS_FLAG, 32'h1 << k);
    rd(CT_OFS_FLAG, q);
    chk("flag_cleared", {31'h0, q[k]}, 32'h0);
  endtask

  // registers and raised flags must all fall back to reset values mid-run
  task automatic t_mid_reset();
    wr(CT_OFS_ENABLE, 32'hf);
    wr(CT_OFS_PRIO, 32'h3);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rate();
    t_tap(0);
    t_tap(1);
    t_tap(2);
    t_tap(3);
    t_mid_reset();
    finish_test();
  end

  // a full wrap takes about 131k clocks
  initial
  begin
    repeat (200000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
endmodule // ct_clock_timer_tb
